// >>> ctic_pkg.sv
// shared constants, modes and carriers for the counter/timer and interrupt control block
// assumes a classic wishbone master and a sequencer on the same clock
package ctic_pkg;
    localparam int ADR_W = 4;
    localparam logic [ADR_W-1:0] ADR_CMD = 4'h0;
    localparam logic [ADR_W-1:0] ADR_STAT = 4'h4;
    localparam logic [ADR_W-1:0] ADR_XPT = 4'h8;
    localparam logic [ADR_W-1:0] ADR_GEC = 4'hC;

    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_LDC = 5'h01;
    localparam logic [4:0] OP_STOP_COUNTER_OP = 5'h02;
    localparam logic [4:0] OP_MODE_EV1 = 5'h03;
    localparam logic [4:0] OP_MODE_EV2 = 5'h04;
    localparam logic [4:0] OP_MODE_TMR = 5'h05;
    localparam logic [4:0] OP_MODE_PD1 = 5'h06;
    localparam logic [4:0] OP_MODE_PD2 = 5'h07;
    localparam logic [4:0] OP_DTC = 5'h08;
    localparam logic [4:0] OP_ETQ = 5'h09;
    localparam logic [4:0] OP_SEQ = 5'h0A;
    localparam logic [4:0] OP_REQ = 5'h0B;
    localparam logic [4:0] OP_CIE = 5'h0C;
    localparam logic [4:0] OP_CID = 5'h0D;
    localparam logic [4:0] OP_XIE = 5'h0E;
    localparam logic [4:0] OP_XID = 5'h0F;
    localparam logic [4:0] OP_RET = 5'h10;
    localparam logic [4:0] OP_DIS = 5'h11;
    localparam logic [4:0] OP_BCI = 5'h12;
    localparam logic [4:0] OP_BXI = 5'h13;
    localparam logic [4:0] OP_GEC = 5'h14;

    localparam logic [7:0] CNT_RELOAD_AT = 8'h01;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] IR_RESET = 8'h00;
    localparam logic [3:0] X_IRQ = 4'h2;
    localparam logic [3:0] P_IRQ = 4'h1;
    localparam logic [3:0] XP_CLEAR = 4'h0;
    localparam logic [7:0] T_RESET = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    localparam int INIT_PULSES = 9;
    localparam int PRESC_DIV_DEF = 32;
    localparam int SYNC_PINS = 3;

    typedef enum logic [5:0]
    {
        MODE_STOP = 6'b00_0001,
        MODE_EV1 = 6'b00_0010,
        MODE_EV2 = 6'b00_0100,
        MODE_TMR = 6'b00_1000,
        MODE_PD1 = 6'b01_0000,
        MODE_PD2 = 6'b10_0000
    } ctic_mode_t;

    typedef enum logic [1:0]
    {
        SEQ_INIT = 2'b01,
        SEQ_RUN = 2'b10
    } ctic_seq_t;

    typedef struct packed
    {
        logic branch_taken;
        logic master_irq_enable;
        logic external_irq_enable;
        logic counter_irq_enable;
        logic q;
        logic toggle_output_enable_op;
        logic ext_pend;
        logic counter_irq_latch;
        logic [1:0] zero;
        logic [5:0] mode;
        logic [7:0] hold;
        logic [7:0] cnt;
    } ctic_status_t;

    typedef struct packed
    {
        logic valid;
        logic [4:0] op;
        logic [7:0] operand;
    } ctic_cmd_t;
endpackage

// >>> ctic_top.sv
// counter/timer with reload, prescaler and interrupt enable/arbitration, plus init cycle
// assumes I_TPA and I_INSTR_DONE come from sequencer logic on I_CLK; flag and irq pins are async
//
// Operation
// - external request is used unlatched; counter requests sit in the latch until cleared.
// - stepping on from 01 reloads holding value, sets latch, counting continues.
// - counter preset to zero runs 256 counts before reload.
// - each request serviced only with its own enable and master enable set.
// - all three enables on after reset and init cycle; ops set or clear each individually.
// - branch ops test pending requests regardless of all enables.
// - latch clears on taken counter branch, reset, or load while stopped.
// - unclear latch after service immediately requests interrupt again.
// - load while stopped fills counter and holding register, clears latch.
// - load while running fills holding only; used at next reload.
// - event modes count falling edges of flag input one or two.
// - timer mode: divide-by-PRESC_DIV (32 by default) prescaler on first timing pulse rising edges.
// - prescaler held reset outside timer mode, at reset and after stop.
// - pulse modes count first timing pulse rises while gate flag is low.
// - gate rising ends pulse mode with interrupt; underflow interrupts, keeps counting.
// - mode change keeps count; flags stay testable while used by counter.
// - stop op clears mode and halts; software stops before read or soft decrement.
// - toggle enabled flips output flag on each step from 01.
// - toggle disabled by stopped load, reset, taken counter branch; set/reset output always act.
// - reset clears instruction register, sets two enables, stops counter, output flag low.
// - nine-pulse init cycle sets master enable, saves X,P to T, clears X,P,R0.
// - no interrupt service during init; O_IRQ held low until init ends.
// - accepted interrupt saves X,P in T, sets X=2, P=1, clears master enable.
module ctic_top
    import ctic_pkg::*;
#(
    parameter int PRESC_DIV = PRESC_DIV_DEF
)
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [ctic_pkg::ADR_W-1:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    input wire logic I_FLAG_INPUT_ONE_N,
    input wire logic I_FLAG_INPUT_TWO_N,
    input wire logic I_EXT_IRQ_N,
    input wire logic I_TPA,
    input wire logic I_INSTR_DONE,
    output logic O_Q,
    output logic O_IRQ,
    output logic O_IRQ_TAKEN,
    output logic O_INIT_ACTIVE,
    output logic O_R0_CLEAR,
    output logic O_FLAG_ONE,
    output logic O_FLAG_TWO
);
    localparam int PW = (PRESC_DIV > 1) ? $clog2(PRESC_DIV) : 1;
    localparam logic [PW-1:0] PRESC_TOP = PW'(PRESC_DIV - 1);
    localparam logic [PW-1:0] PRESC_ZERO = '0;
    localparam logic [3:0] INIT_LAST = 4'(INIT_PULSES - 1);

    if (PRESC_DIV < 2 || PRESC_DIV > 256)
        $error("PRESC_DIV out of range");

    // two-flop synchronisers for the async pins
    logic [SYNC_PINS-1:0] pin_raw;
    logic [SYNC_PINS-1:0] sync1_r;
    logic [SYNC_PINS-1:0] sync2_r;
    assign pin_raw = {I_EXT_IRQ_N, I_FLAG_INPUT_TWO_N, I_FLAG_INPUT_ONE_N};
    for (genvar g = 0; g < SYNC_PINS; g++)
    begin : g_sync
        always_ff @(posedge I_CLK)
        begin
            if (I_SRST)
            begin
                sync1_r[g] <= 1'b1;
                sync2_r[g] <= 1'b1;
            end
            else
            begin
                sync1_r[g] <= pin_raw[g];
                sync2_r[g] <= sync1_r[g];
            end
        end
    end

    logic f1_d_r, f2_d_r, tpa_d_r;
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            f1_d_r <= 1'b1;
            f2_d_r <= 1'b1;
            tpa_d_r <= 1'b0;
        end
        else
        begin
            f1_d_r <= sync2_r[0];
            f2_d_r <= sync2_r[1];
            tpa_d_r <= I_TPA;
        end
    end
    logic f1_fall, f2_fall, f1_rise, f2_rise, tpa_rise, ext_pend;
    assign f1_fall = f1_d_r & ~sync2_r[0];
    assign f2_fall = f2_d_r & ~sync2_r[1];
    assign f1_rise = ~f1_d_r & sync2_r[0];
    assign f2_rise = ~f2_d_r & sync2_r[1];
    assign tpa_rise = I_TPA & ~tpa_d_r;
    assign ext_pend = ~sync2_r[2];

    // wishbone slave: ack one cycle after the strobe, zero data on unmapped reads
    logic req;
    ctic_cmd_t cmd;
    assign req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    always_comb
    begin
        cmd.valid = req & I_WB_WE & I_WB_SEL[0] & (I_WB_ADR == ADR_CMD);
        cmd.op = I_WB_DAT[4:0];
        cmd.operand = I_WB_DAT[15:8];
    end
    logic wr_xp;
    assign wr_xp = req & I_WB_WE & I_WB_SEL[0] & (I_WB_ADR == ADR_XPT);

    function automatic logic is_op(input ctic_cmd_t c, input logic [4:0] code);
        is_op = c.valid && (c.op == code);
    endfunction

    ctic_mode_t mode_r;
    logic [7:0] cnt_r, hold_r, ir_r, gec_r, t_r;
    logic [3:0] x_r, p_r, init_cnt_r;
    logic [PW-1:0] presc_r;
    logic cil_r, cie_r, xie_r, mie_r, etq_r, branch_r;
    ctic_seq_t seq_r;
    logic running, presc_tick, count_evt, at_reload, pd_end, cil_set, cil_clr, init_done, accept;
    logic irq_req;

    assign running = (mode_r != MODE_STOP);

    // prescaler: free only in timer mode
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST || mode_r != MODE_TMR || is_op(cmd, OP_STOP_COUNTER_OP))
            presc_r <= PRESC_TOP;
        else if (tpa_rise)
            presc_r <= (presc_r == PRESC_ZERO) ? PRESC_TOP : presc_r - PW'(1);
    end
    assign presc_tick = (mode_r == MODE_TMR) && tpa_rise && (presc_r == PRESC_ZERO);

    // one counting source per mode; soft decrement acts in any mode but is meant for stopped
    always_comb
    begin
        case (mode_r)
            MODE_EV1: count_evt = f1_fall;
            MODE_EV2: count_evt = f2_fall;
            MODE_TMR: count_evt = presc_tick;
            MODE_PD1: count_evt = tpa_rise & ~sync2_r[0];
            MODE_PD2: count_evt = tpa_rise & ~sync2_r[1];
            default: count_evt = 1'b0;
        endcase
        if (is_op(cmd, OP_DTC))
            count_evt = 1'b1;
    end
    assign at_reload = count_evt && (cnt_r == CNT_RELOAD_AT);
    assign pd_end = ((mode_r == MODE_PD1) && f1_rise) || ((mode_r == MODE_PD2) && f2_rise);

    // counter and holding register
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            cnt_r <= CNT_ZERO;
            hold_r <= CNT_ZERO;
        end
        else if (is_op(cmd, OP_LDC))
        begin
            hold_r <= cmd.operand;
            if (!running)
                cnt_r <= cmd.operand;
            else if (at_reload)
                cnt_r <= hold_r;
            else if (count_evt)
                cnt_r <= cnt_r - 8'h01;
        end
        else if (at_reload)
            cnt_r <= hold_r;
        else if (count_evt)
            cnt_r <= cnt_r - 8'h01; // zero wraps to FF for 256 counts
    end

    // mode: changes never touch the count
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            mode_r <= MODE_STOP;
        else if (cmd.valid)
        begin
            case (cmd.op)
                OP_STOP_COUNTER_OP: mode_r <= MODE_STOP;
                OP_MODE_EV1: mode_r <= MODE_EV1;
                OP_MODE_EV2: mode_r <= MODE_EV2;
                OP_MODE_TMR: mode_r <= MODE_TMR;
                OP_MODE_PD1: mode_r <= MODE_PD1;
                OP_MODE_PD2: mode_r <= MODE_PD2;
                default: mode_r <= pd_end ? MODE_STOP : mode_r;
            endcase
        end
        else if (pd_end)
            mode_r <= MODE_STOP;
    end

    // counter interrupt latch: a set in the clearing cycle wins
    assign cil_set = at_reload || pd_end;
    assign cil_clr = (is_op(cmd, OP_BCI) && cil_r) || (is_op(cmd, OP_LDC) && !running);
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            cil_r <= 1'b0;
        else
            cil_r <= (cil_r & ~cil_clr) | cil_set;
    end

    // toggle enable and output flag
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            etq_r <= 1'b0;
        else if (is_op(cmd, OP_ETQ))
            etq_r <= 1'b1;
        else if (cil_clr)
            etq_r <= 1'b0;
    end
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
            O_Q <= 1'b0;
        else if (is_op(cmd, OP_SEQ))
            O_Q <= 1'b1;
        else if (is_op(cmd, OP_REQ))
            O_Q <= 1'b0;
        else if (etq_r && at_reload)
            O_Q <= ~O_Q;
    end

    // enables
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            cie_r <= 1'b1;
            xie_r <= 1'b1;
        end
        else if (cmd.valid)
        begin
            case (cmd.op)
                OP_CIE: cie_r <= 1'b1;
                OP_CID: cie_r <= 1'b0;
                OP_XIE: xie_r <= 1'b1;
                OP_XID: xie_r <= 1'b0;
                default: cie_r <= cie_r;
            endcase
        end
    end

    // init sequencer: nine cycles after reset release
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            seq_r <= SEQ_INIT;
            init_cnt_r <= 4'h0;
        end
        else
        begin
            case (seq_r)
                SEQ_INIT:
                begin
                    init_cnt_r <= init_cnt_r + 4'h1;
                    if (init_cnt_r == INIT_LAST)
                        seq_r <= SEQ_RUN;
                end
                SEQ_RUN: seq_r <= SEQ_RUN;
                default: seq_r <= SEQ_INIT;
            endcase
        end
    end
    assign init_done = (seq_r == SEQ_INIT) && (init_cnt_r == INIT_LAST);

    assign irq_req = mie_r && ((cil_r && cie_r) || (ext_pend && xie_r));
    assign accept = I_INSTR_DONE && O_IRQ && (seq_r == SEQ_RUN);

    // designators, T and master enable
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            mie_r <= 1'b0;
            t_r <= T_RESET;
            x_r <= XP_CLEAR;
            p_r <= XP_CLEAR;
        end
        else if (init_done)
        begin
            mie_r <= 1'b1;
            t_r <= {x_r, p_r};
            x_r <= XP_CLEAR;
            p_r <= XP_CLEAR;
        end
        else if (accept)
        begin
            mie_r <= 1'b0;
            t_r <= {x_r, p_r};
            x_r <= X_IRQ;
            p_r <= P_IRQ;
        end
        else if (is_op(cmd, OP_RET) || is_op(cmd, OP_DIS))
        begin
            mie_r <= is_op(cmd, OP_RET);
            x_r <= cmd.operand[7:4];
            p_r <= cmd.operand[3:0];
        end
        else if (wr_xp)
        begin
            x_r <= I_WB_DAT[7:4];
            p_r <= I_WB_DAT[3:0];
        end
    end

    // instruction register, branch result and counter snapshot
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            ir_r <= IR_RESET;
            branch_r <= 1'b0;
            gec_r <= CNT_ZERO;
        end
        else if (cmd.valid)
        begin
            ir_r <= {3'b000, cmd.op};
            if (cmd.op == OP_BCI)
                branch_r <= cil_r;
            else if (cmd.op == OP_BXI)
                branch_r <= ext_pend;
            if (cmd.op == OP_GEC)
                gec_r <= cnt_r;
        end
    end

    // registered outputs
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            O_IRQ <= 1'b0;
            O_IRQ_TAKEN <= 1'b0;
            O_INIT_ACTIVE <= 1'b1;
            O_R0_CLEAR <= 1'b0;
            O_FLAG_ONE <= 1'b1;
            O_FLAG_TWO <= 1'b1;
        end
        else
        begin
            O_IRQ <= irq_req & (seq_r == SEQ_RUN) & ~accept;
            O_IRQ_TAKEN <= accept;
            O_INIT_ACTIVE <= (seq_r == SEQ_INIT) && !init_done;
            O_R0_CLEAR <= init_done;
            O_FLAG_ONE <= sync2_r[0];
            O_FLAG_TWO <= sync2_r[1];
        end
    end

    ctic_status_t stat;
    always_comb
    begin
        stat.branch_taken = branch_r;
        stat.master_irq_enable = mie_r;
        stat.external_irq_enable = xie_r;
        stat.counter_irq_enable = cie_r;
        stat.q = O_Q;
        stat.toggle_output_enable_op = etq_r;
        stat.ext_pend = ext_pend;
        stat.counter_irq_latch = cil_r;
        stat.zero = 2'b00;
        stat.mode = mode_r;
        stat.hold = hold_r;
        stat.cnt = cnt_r;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= RD_ZERO;
        end
        else
        begin
            O_WB_ACK <= req;
            if (req && !I_WB_WE)
            begin
                case (I_WB_ADR)
                    ADR_CMD: O_WB_DAT <= {24'h00_0000, ir_r};
                    ADR_STAT: O_WB_DAT <= stat;
                    ADR_XPT: O_WB_DAT <= {13'h0000, O_INIT_ACTIVE, sync2_r[1], sync2_r[0], t_r, x_r, p_r};
                    ADR_GEC: O_WB_DAT <= {24'h00_0000, gec_r};
                    default: O_WB_DAT <= RD_ZERO;
                endcase
            end
        end
    end

    sequence s_reload_src;
        count_evt && (cnt_r == CNT_RELOAD_AT) && !is_op(cmd, OP_LDC);
    endsequence
    sequence s_reload_done(logic [7:0] h);
        (cnt_r == h) && cil_r;
    endsequence
    property p_reload;
        logic [7:0] h;
        @(posedge I_CLK) disable iff (I_SRST)
        (s_reload_src, h = hold_r) |=> s_reload_done(h);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload at 01");

    property p_wrap;
        @(posedge I_CLK) disable iff (I_SRST)
        count_evt && (cnt_r == CNT_ZERO) && !is_op(cmd, OP_LDC) |=> (cnt_r == CNT_MAX) && (cil_r == $past(cil_r));
    endproperty
    a_wrap: assert property (p_wrap) else $error("zero did not wrap");

    property p_ldc_stopped;
        @(posedge I_CLK) disable iff (I_SRST)
        is_op(cmd, OP_LDC) && !running |=> cnt_r == $past(cmd.operand) && hold_r == $past(cmd.operand) && !cil_r && !etq_r;
    endproperty
    a_ldc_stopped: assert property (p_ldc_stopped) else $error("stopped load wrong");

    property p_ldc_running;
        @(posedge I_CLK) disable iff (I_SRST)
        is_op(cmd, OP_LDC) && running |=> (cil_r == ($past(cil_r) || $past(cil_set))) && hold_r == $past(cmd.operand);
    endproperty
    a_ldc_running: assert property (p_ldc_running) else $error("running load wrong");

    property p_presc_hold;
        @(posedge I_CLK) disable iff (I_SRST)
        mode_r != MODE_TMR |=> presc_r == PRESC_TOP;
    endproperty
    a_presc_hold: assert property (p_presc_hold) else $error("prescaler not held");

    property p_pd_end;
        @(posedge I_CLK) disable iff (I_SRST)
        pd_end && !cmd.valid |=> mode_r == MODE_STOP && cil_r;
    endproperty
    a_pd_end: assert property (p_pd_end) else $error("pulse end not handled");

    property p_bci;
        @(posedge I_CLK) disable iff (I_SRST)
        is_op(cmd, OP_BCI) && cil_r && !cil_set |=> !cil_r && !etq_r && branch_r;
    endproperty
    a_bci: assert property (p_bci) else $error("branch did not clear latch");

    property p_irq;
        @(posedge I_CLK) disable iff (I_SRST)
        O_IRQ |-> $past(mie_r) && ($past(cil_r && cie_r) || $past(ext_pend && xie_r));
    endproperty
    a_irq: assert property (p_irq) else $error("request without enable");

    property p_accept;
        @(posedge I_CLK) disable iff (I_SRST)
        accept |=> x_r == X_IRQ && p_r == P_IRQ && !mie_r && t_r == $past({x_r, p_r}) && O_IRQ_TAKEN;
    endproperty
    a_accept: assert property (p_accept) else $error("interrupt entry wrong");

    property p_init;
        @(posedge I_CLK)
        $fell(I_SRST) |-> O_INIT_ACTIVE [*8] ##1 O_INIT_ACTIVE ##1 !O_INIT_ACTIVE && O_R0_CLEAR && mie_r && x_r == XP_CLEAR;
    endproperty
    a_init: assert property (p_init) else $error("init cycle wrong");

    property p_no_irq_init;
        @(posedge I_CLK) disable iff (I_SRST)
        O_INIT_ACTIVE |-> !O_IRQ && !accept;
    endproperty
    a_no_irq_init: assert property (p_no_irq_init) else $error("service during init");

    property p_toggle;
        @(posedge I_CLK) disable iff (I_SRST)
        etq_r && at_reload && !is_op(cmd, OP_SEQ) && !is_op(cmd, OP_REQ) |=> O_Q != $past(O_Q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("output flag did not toggle");
endmodule

// >>> ctic_partner.sv
// far-side model: flag pins, external request and first timing pulse
// assumes its tasks are called from one bench thread on the block clock
module ctic_partner
(
    input wire logic i_clk,
    output logic o_tpa,
    output logic [1:0] o_flag_n,
    output logic o_ext_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {o_tpa, o_flag_n, o_ext_n} = 4'h7;
    task automatic timing_pulse_first(input int n);
        repeat (n)
        begin
            @(posedge i_clk) o_tpa <= 1'b1;
            @(posedge i_clk) o_tpa <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
    endtask
    // each level held 4 clocks so the two-flop sync and edge detect see it
    task automatic flag(input int i, input int n);
        repeat (n)
        begin
            @(posedge i_clk) o_flag_n[i] <= 1'b0;
            repeat (4) @(posedge i_clk);
            o_flag_n[i] <= 1'b1;
            repeat (4) @(posedge i_clk);
        end
    endtask
    task automatic gate(input int i, input logic lv);
        @(posedge i_clk) o_flag_n[i] <= lv;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic ext(input logic lv);
        @(posedge i_clk) o_ext_n <= lv;
        repeat (4) @(posedge i_clk);
    endtask
endmodule

// >>> counter_timer_interrupt_control_test.sv
// self-checking bench: wishbone tasks, integer model of counter and latch
// assumes the partner model drives flag, request and timing pulse pins
module counter_timer_interrupt_control_test;
    import ctic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic done = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] o_dat;
    logic ack, q, irq, taken, init, r0clr, timing_pulse_first, ext_n;
    logic [1:0] flg_n, fo;
    logic [7:0] m_cnt, m_hold;
    logic [5:0] m_mode;
    logic m_cil, m_q, m_etq;
    int failures = 0;
    int n_compared = 0;
    int seed, v, k;
    always #20 clk = ~clk;
    ctic_partner p(.i_clk(clk), .o_tpa(timing_pulse_first), .o_flag_n(flg_n), .o_ext_n(ext_n));
    ctic_top #(.PRESC_DIV(DIV)) uut(.I_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(o_dat),
        .O_WB_ACK(ack), .I_FLAG_INPUT_ONE_N(flg_n[0]), .I_FLAG_INPUT_TWO_N(flg_n[1]),
        .I_EXT_IRQ_N(ext_n), .I_TPA(timing_pulse_first), .I_INSTR_DONE(done), .O_Q(q), .O_IRQ(irq),
        .O_IRQ_TAKEN(taken), .O_INIT_ACTIVE(init), .O_R0_CLEAR(r0clr), .O_FLAG_ONE(fo[0]),
        .O_FLAG_TWO(fo[1]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h1, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        rdat = o_dat;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1)
        begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic op(input logic [4:0] c, input logic [7:0] x);
        wb(1'b1, ADR_CMD, {16'h0000, x, 3'b000, c});
    endtask
    function automatic void step();
        if (m_cnt == 8'h01)
        begin
            m_cnt = m_hold;
            m_cil = 1'b1;
            m_q = m_q ^ m_etq;
        end
        else
            m_cnt = m_cnt - 8'h01;
    endfunction
    task automatic stat();
        wb(1'b0, ADR_STAT, 32'h0000_0000);
        chk({rdat[27], rdat[24], rdat[21:0]}, {m_q, m_cil, m_mode, m_hold, m_cnt});
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test();
    end
    initial
    begin
        seed = 32'h7a8a_9cb7;
        {m_cnt, m_hold, m_mode, m_cil, m_q, m_etq} = {16'h0000, 6'h01, 3'b000};
        p.ext(1'b0);
        repeat (15) @(posedge clk);
        srst <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk({irq, init, q}, 3'b010);
        @(posedge clk);
        #1 chk({init, r0clr}, 2'b01);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        wb(1'b0, ADR_XPT, 32'h0000_0000);
        chk(rdat[18:0], 19'h3_0000);
        wb(1'b0, ADR_STAT, 32'h0000_0000);
        chk(rdat[31:16], 16'h7201);
        wb(1'b0, 4'h2, 32'h0000_0000);
        chk(rdat, RD_ZERO);
        op(OP_BXI, 8'h00);
        wb(1'b0, ADR_STAT, 32'h0000_0000);
        chk(rdat[31], 1'b1);
        op(OP_XID, 8'h00);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        p.ext(1'b1);
        op(OP_XIE, 8'h00);
        v = 2 + $unsigned($random(seed)) % 5;
        op(OP_ETQ, 8'h00);
        op(OP_LDC, v[7:0]);
        {m_cnt, m_hold} = {v[7:0], v[7:0]};
        stat();
        op(OP_ETQ, 8'h00);
        m_etq = 1'b1;
        repeat (v + 1)
        begin
            op(OP_DTC, 8'h00);
            step();
            stat();
        end
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        #1 chk({taken, irq}, 2'b10);
        wb(1'b0, ADR_XPT, 32'h0000_0000);
        chk(rdat[15:0], 16'h0021);
        op(OP_RET, 8'h00);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        op(OP_BCI, 8'h00);
        {m_cil, m_etq} = 2'b00;
        stat();
        op(OP_MODE_TMR, 8'h00);
        m_mode = 6'h08;
        op(OP_LDC, 8'h05);
        m_hold = 8'h05;
        op(OP_REQ, 8'h00);
        m_q = 1'b0;
        k = m_cnt + 1;
        p.timing_pulse_first(DIV * k);
        repeat (k) step();
        stat();
        p.timing_pulse_first(DIV - 1);
        op(OP_STOP_COUNTER_OP, 8'h00);
        op(OP_MODE_TMR, 8'h00);
        p.timing_pulse_first(DIV - 1);
        op(OP_STOP_COUNTER_OP, 8'h00);
        m_mode = 6'h01;
        stat();
        for (int i = 0; i < 2; i++)
        begin
            k = 1 + $unsigned($random(seed)) % 4;
            op(OP_LDC, 8'h09);
            {m_cnt, m_hold, m_cil} = {16'h0909, 1'b0};
            op(OP_MODE_EV1 + i[4:0], 8'h00);
            p.flag(i, k);
            op(OP_STOP_COUNTER_OP, 8'h00);
            repeat (k) step();
            stat();
            op(OP_MODE_PD1 + i[4:0], 8'h00);
            p.gate(i, 1'b0);
            chk(fo[i], 1'b0);
            p.timing_pulse_first(k);
            p.gate(i, 1'b1);
            repeat (k) step();
            m_cil = 1'b1;
            stat();
        end
        op(OP_LDC, 8'h00);
        {m_cnt, m_hold, m_cil} = 17'h0_0000;
        repeat (256) op(OP_DTC, 8'h00);
        repeat (256) step();
        stat();
        end_of_test();
    end
endmodule
